//--- design/serial_port_consts.svh
// Purpose: constants for the serial port control register zero block
// Assumes: 8-bit register port, byte addresses, one 200 MHz clock
// Notes: offsets, field positions, reset values and codes live here
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// register byte addresses
`define ADDR_CTRL0 8'h00
`define ADDR_TXDATA 8'h01
`define ADDR_PORT_DATA 8'h02
`define ADDR_PORT_DIR 8'h03
`define ADDR_IRQ_STATUS 8'h04
`define ADDR_IRQ_MASK 8'h05
`define ADDR_MODE 8'h06
`define ADDR_BRG 8'h07

// control register zero field positions
`define CTRL0_CLK_LO 0
`define CTRL0_CLK_HI 1
`define CTRL0_HS_SEL 2
`define CTRL0_TX_EMPTY 3
`define CTRL0_HS_DIS 4
`define CTRL0_BIT_ORDER 7

// reset values
`define CTRL0_RESET 8'h08
`define MODE_RESET 2'h2
`define BRG_RESET 8'h00
`define BYTE_ZERO 8'h00

// clock source codes
`define CLK_SRC_F1 2'h0
`define CLK_SRC_F8 2'h1
`define CLK_SRC_F32 2'h2

// prescaler terminal counts
`define F8_LAST 3'h7
`define F32_LAST 5'h1f

// frame modes
`define MODE_SYNC 2'h0
`define MODE_UART7 2'h1
`define MODE_UART8 2'h2
`define MODE_UART9 2'h3

// last data bit index per frame length
`define LAST_BIT7 4'h6
`define LAST_BIT8 4'h7
`define LAST_BIT9 4'h8

// interrupt status bit positions
`define IRQ_DONE 0
`define IRQ_BUF_EMPTY 1

`endif

//--- design/serial_port_pkg.sv
// Purpose: shared types of the serial port control block
// Assumes: constants come from serial_port_consts.svh
// Notes: the control register travels as one packed struct
package serial_port_pkg;

    // control register zero, bit 7 down to bit 0
    typedef struct packed {
        logic bit_order;
        logic [1:0] reserved;
        logic hs_disable;
        logic tx_empty;
        logic hs_select;
        logic [1:0] clk_src;
    } ctrl0_type;

    // transmitter sequence
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_STOP
    } tx_state_type;

endpackage

//--- design/brg_divider.sv
// Purpose: prescaler and baud-rate generator producing a bit tick
// Assumes: divisor n gives one tick every n+1 source ticks
// Notes: the forbidden source code stops the tick altogether
`timescale 1ns/1ps
`include "serial_port_consts.svh"

module brg_divider #(
    parameter int DIV_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [1:0] clk_src,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick
);

    logic [4:0] pre_reg;
    logic [DIV_W-1:0] cnt_reg;
    logic src_tick;
    logic cnt_zero;

    // source select; code 11 yields no tick so a bad setting stalls safely
    assign src_tick = (clk_src == `CLK_SRC_F1) ? 1'b1 :
        (clk_src == `CLK_SRC_F8) ? (pre_reg[2:0] == `F8_LAST) :
        (clk_src == `CLK_SRC_F32) ? (pre_reg == `F32_LAST) :
        1'b0;
    assign cnt_zero = (cnt_reg == '0);

    // free running prescaler
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pre_reg <= 5'h00;
        end else begin
            pre_reg <= pre_reg + 5'h01;
        end
    end

    // reload counter; the tick is a flop so downstream sees a clean pulse
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            tick <= src_tick && cnt_zero;
            if (src_tick) begin
                cnt_reg <= cnt_zero ? divisor : cnt_reg - 1'b1;
            end
        end
    end

endmodule

//--- design/serial_port_control_zero.sv
// Purpose: serial port with control register zero, transmitter and pin
// Assumes: register port strobes are one cycle long and synchronous
// Notes: the handshake pin and serial output are driven from flops
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "serial_port_consts.svh"

module serial_port_control_zero #(
    parameter int DIV_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    output logic txd,
    input wire logic hs_pin_in,
    output logic hs_pin_out,
    output logic hs_pin_oe,
    output logic irq
);
    import serial_port_pkg::*;

    // software visible state
    serial_port_pkg::ctrl0_type ctrl_reg;
    logic [1:0] mode_reg;
    logic [DIV_W-1:0] brg_reg;
    logic port_data_reg;
    logic port_dir_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;

    // transmitter state
    serial_port_pkg::tx_state_type state_reg;
    serial_port_pkg::tx_state_type state_next;
    logic [8:0] shift_reg;
    logic [8:0] shift_next;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic [7:0] buf_reg;
    logic buf_full_reg;
    logic tx_empty_reg;

    // pin input synchroniser, first stage read only by the second
    logic pin_meta_reg;
    logic pin_sync_reg;

    // decoded strobes
    wire wr_ctrl = wr_stb && (addr == `ADDR_CTRL0);
    wire wr_txdata = wr_stb && (addr == `ADDR_TXDATA);
    wire wr_port_data = wr_stb && (addr == `ADDR_PORT_DATA);
    wire wr_port_dir = wr_stb && (addr == `ADDR_PORT_DIR);
    wire wr_mask = wr_stb && (addr == `ADDR_IRQ_MASK);
    wire wr_mode = wr_stb && (addr == `ADDR_MODE);
    wire wr_brg = wr_stb && (addr == `ADDR_BRG);
    wire rd_status = rd_stb && (addr == `ADDR_IRQ_STATUS);

    // baud tick from the prescaler and generator
    logic bit_tick;

    brg_divider #(
        .DIV_W(DIV_W)
    ) u_brg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_src(ctrl_reg.clk_src),
        .divisor(brg_reg),
        .tick(bit_tick)
    );

    // handshake decode
    wire hs_active = !ctrl_reg.hs_disable;
    wire cts_mode = hs_active && !ctrl_reg.hs_select;
    wire rts_mode = hs_active && ctrl_reg.hs_select;
    // clear-to-send is active low; relies on the pin being an input
    wire cts_ok = !cts_mode || !pin_sync_reg;

    // bit order only applies to 8-bit frames; other lengths stay lsb first
    wire order_ok = (mode_reg == `MODE_SYNC) ||
        (mode_reg == `MODE_UART8);
    wire msb_first = ctrl_reg.bit_order && order_ok;
    wire sync_mode = (mode_reg == `MODE_SYNC);

    // last data bit index for the frame length
    wire [3:0] last_bit = (mode_reg == `MODE_UART7) ? `LAST_BIT7 :
        (mode_reg == `MODE_UART9) ? `LAST_BIT9 : `LAST_BIT8;

    // transmit register empty tracks the shifter, not the buffer
    wire tx_idle = (state_reg == TX_IDLE);

    // a character is taken from the buffer on a tick while idle
    // while clear-to-send is high the character simply waits in the buffer
    wire load = bit_tick && (state_reg == TX_IDLE) && buf_full_reg && cts_ok;
    wire last_data = (bit_cnt_reg == last_bit);
    wire frame_done = bit_tick && (((state_reg == TX_DATA) && last_data &&
        sync_mode) || (state_reg == TX_STOP));

    // current serial bit; msb first in 8-bit frames reads bit 7
    wire data_bit = msb_first ? shift_reg[7] : shift_reg[0];

    // transmitter next state
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        case (state_reg)
            TX_IDLE: begin
                if (load) begin
                    shift_next = {1'b0, buf_reg};
                    bit_cnt_next = 4'h0;
                    state_next = sync_mode ? TX_DATA : TX_START;
                end
            end
            TX_START: begin
                if (bit_tick) begin
                    state_next = TX_DATA;
                end
            end
            TX_DATA: begin
                if (bit_tick) begin
                    shift_next = msb_first ? {shift_reg[7:0], 1'b0} :
                        {1'b0, shift_reg[8:1]};
                    bit_cnt_next = bit_cnt_reg + 4'h1;
                    if (last_data) begin
                        state_next = sync_mode ? TX_IDLE : TX_STOP;
                    end
                end
            end
            TX_STOP: begin
                if (bit_tick) begin
                    state_next = TX_IDLE;
                end
            end
            default: begin
                state_next = TX_IDLE;
            end
        endcase
    end

    // serial output level; idle and stop are mark
    wire txd_next = (state_reg == TX_START) ? 1'b0 :
        (state_reg == TX_DATA) ? data_bit : 1'b1;

    // pin: request-to-send overrides port data and direction
    // ready level is low while the buffer can take another character
    wire pin_out_next = rts_mode ? buf_full_reg : port_data_reg;
    wire pin_oe_next = rts_mode ? 1'b1 : port_dir_reg;

    // interrupt events set sticky bits; a set beats the clearing read,
    // so an event landing in the read cycle is never lost
    wire [1:0] irq_events;
    wire [1:0] irq_status_next;
    assign irq_events[`IRQ_DONE] = frame_done;
    assign irq_events[`IRQ_BUF_EMPTY] = load;

    // one sticky bit per event
    genvar gi;
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
        assign irq_status_next[gi] = irq_events[gi] ||
            (irq_status_reg[gi] && !rd_status);
    end

    // read data of control zero; reserved bits read zero
    wire [7:0] ctrl_rd = {ctrl_reg.bit_order, 2'b00, ctrl_reg.hs_disable,
        tx_empty_reg, ctrl_reg.hs_select, ctrl_reg.clk_src};

    // port data reads the latch when output, the pin level when input
    wire port_rd = port_dir_reg ? port_data_reg : pin_sync_reg;

    // read mux; unmapped addresses read zero
    wire [7:0] rd_mux =
        (addr == `ADDR_CTRL0) ? ctrl_rd :
        (addr == `ADDR_TXDATA) ? buf_reg :
        (addr == `ADDR_PORT_DATA) ? {7'h00, port_rd} :
        (addr == `ADDR_PORT_DIR) ? {7'h00, port_dir_reg} :
        (addr == `ADDR_IRQ_STATUS) ? {6'h00, irq_status_reg} :
        (addr == `ADDR_IRQ_MASK) ? {6'h00, irq_mask_reg} :
        (addr == `ADDR_MODE) ? {6'h00, mode_reg} :
        (addr == `ADDR_BRG) ? 8'(brg_reg) : `BYTE_ZERO;

    // synchroniser for the handshake pin; it resets high so clear-to-send
    // reads as not ready until the real pin level has been seen
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= hs_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // control register zero; the empty flag is not stored, so writes drop
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= `CTRL0_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg.clk_src <= wr_data[`CTRL0_CLK_HI:`CTRL0_CLK_LO];
            ctrl_reg.hs_select <= wr_data[`CTRL0_HS_SEL];
            ctrl_reg.hs_disable <= wr_data[`CTRL0_HS_DIS];
            ctrl_reg.bit_order <= wr_data[`CTRL0_BIT_ORDER];
        end
    end

    // frame mode and baud divisor settings
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= `MODE_RESET;
            brg_reg <= DIV_W'(`BRG_RESET);
        end else begin
            if (wr_mode) mode_reg <= wr_data[1:0];
            if (wr_brg) brg_reg <= DIV_W'(wr_data);
        end
    end

    // port latch, port direction and interrupt mask
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            port_data_reg <= 1'b0;
            port_dir_reg <= 1'b0;
            irq_mask_reg <= 2'b00;
        end else begin
            if (wr_port_data) port_data_reg <= wr_data[0];
            if (wr_port_dir) port_dir_reg <= wr_data[0];
            if (wr_mask) irq_mask_reg <= wr_data[1:0];
        end
    end

    // transmit buffer; a write in the load cycle keeps the buffer full
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            buf_reg <= `BYTE_ZERO;
            buf_full_reg <= 1'b0;
        end else begin
            if (wr_txdata) buf_reg <= wr_data;
            buf_full_reg <= wr_txdata || (buf_full_reg && !load);
        end
    end

    // transmitter registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= TX_IDLE;
            shift_reg <= 9'h000;
            bit_cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // empty flag registered so it falls and rises with the serial pin,
    // which lags the state by one clock; reads 1 out of reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tx_empty_reg <= 1'b1;
        end else begin
            tx_empty_reg <= tx_idle;
        end
    end

    // serial output flop; idle level is mark
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            txd <= 1'b1;
        end else begin
            txd <= txd_next;
        end
    end

    // pin drive flops; released out of reset so the pin starts as input
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hs_pin_out <= 1'b0;
            hs_pin_oe <= 1'b0;
        end else begin
            hs_pin_out <= pin_out_next;
            hs_pin_oe <= pin_oe_next;
        end
    end

    // interrupt status and line; the line looks at the next status so it
    // rises in the same cycle as the sticky bit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status_reg <= 2'b00;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq <= |(irq_status_next & irq_mask_reg);
        end
    end

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= `BYTE_ZERO;
        end else begin
            rd_data <= rd_stb ? rd_mux : `BYTE_ZERO;
        end
    end

endmodule

//--- testbench/serial_port_control_zero_properties.sv
// Purpose: port checks of the serial port control block
// Assumes: shadows follow register writes at the edge the block takes them
// Notes: steady means no write during the last four cycles
`timescale 1ns/1ps
`include "serial_port_consts.svh"

module serial_port_control_zero_checker
    import serial_port_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic txd,
    input wire logic hs_pin_in,
    input wire logic hs_pin_out,
    input wire logic hs_pin_oe,
    input wire logic irq
);
    ctrl0_type sh_reg;
    logic dir_reg, pdat_reg, sent_reg;
    logic [2:0] quiet_reg;
    wire steady = quiet_reg == 3'h4;
    wire cts_mode = !sh_reg.hs_disable && !sh_reg.hs_select;
    wire rts_mode = !sh_reg.hs_disable && sh_reg.hs_select;
    wire hit_ctrl = wr_stb && addr == `ADDR_CTRL0;

    // shadows let the pin checks wait until a setting has settled
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sh_reg <= ctrl0_type'(`CTRL0_RESET);
            {dir_reg, pdat_reg, sent_reg} <= 3'h0;
            quiet_reg <= 3'h0;
        end else begin
            if (hit_ctrl) sh_reg <= ctrl0_type'(wr_data);
            if (wr_stb && addr == `ADDR_PORT_DIR) dir_reg <= wr_data[0];
            if (wr_stb && addr == `ADDR_PORT_DATA) pdat_reg <= wr_data[0];
            if (wr_stb && addr == `ADDR_TXDATA) sent_reg <= 1'b1;
            quiet_reg <= wr_stb ? 3'h0 :
                (steady ? quiet_reg : quiet_reg + 3'h1);
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence ctrl_rd_s;
        rd_stb && addr == `ADDR_CTRL0;
    endsequence

    ctrl_fields_a: assert property (ctrl_rd_s |=>
        {rd_data[7:4], rd_data[2:0]} == {$past(sh_reg.bit_order), 2'h0,
        $past(sh_reg.hs_disable), $past(sh_reg.hs_select),
        $past(sh_reg.clk_src)}) else $error("control read mismatch");
    empty_reset_a: assert property (
        ctrl_rd_s ##0 !sent_reg |=> rd_data[3])
        else $error("empty flag low with nothing sent");
    empty_busy_a: assert property (
        ctrl_rd_s ##0 !txd |=> !rd_data[3])
        else $error("empty flag high mid frame");
    cts_input_a: assert property (
        steady && cts_mode && !dir_reg |-> !hs_pin_oe)
        else $error("pin driven in clear-to-send mode");
    rts_drive_a: assert property (
        steady && rts_mode |-> hs_pin_oe)
        else $error("pin not driven in request-to-send mode");
    rts_level_a: assert property (
        steady && rts_mode && !sent_reg |-> !hs_pin_out)
        else $error("request level follows port data");
    port_release_a: assert property (
        steady && sh_reg.hs_disable |-> hs_pin_oe == dir_reg &&
        (!dir_reg || hs_pin_out == pdat_reg))
        else $error("released pin not under port control");
    halt_src_a: assert property (
        steady && sh_reg.clk_src == 2'h3 |-> $stable(txd))
        else $error("serial output moved with source inhibited");
endmodule

bind serial_port_control_zero serial_port_control_zero_checker #(
    .DIV_W(DIV_W)) chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .txd(txd), .hs_pin_in(hs_pin_in), .hs_pin_out(hs_pin_out),
    .hs_pin_oe(hs_pin_oe), .irq(irq));

//--- testbench/serial_peer_model.sv
// Purpose: remote serial peer on the shared handshake wire
// Assumes: clear-to-send is active low and set by the bench
// Notes: the wire shows the block's drive whenever its enable is high
`timescale 1ns/1ps

module serial_peer_model (
    input wire logic hs_pin_out,
    input wire logic hs_pin_oe,
    input wire logic cts_n,
    output logic hs_pin_in
);
    // the peer yields the wire while the block drives it
    assign hs_pin_in = hs_pin_oe ? hs_pin_out : cts_n;
endmodule

//--- testbench/serial_port_control_zero_bench.sv
// Purpose: self-checking bench of the serial port control block
// Assumes: baud divisor 7, so a bit lasts 8, 64 or 256 clocks
// Notes: frames are sampled near the middle of each bit
`timescale 1ns/1ps
`include "serial_port_consts.svh"

module serial_port_control_zero_bench;
    import serial_port_pkg::*;
    localparam logic [7:0] DATA = 8'ha5;
    logic clk_sys, sys_rst, wr_stb, rd_stb, cts_n;
    logic [7:0] addr, wr_data, rd_data, d;
    logic txd, hs_pin_in, hs_pin_out, hs_pin_oe, irq;
    int err_count = 0;
    int num_checks = 0;

    serial_port_control_zero #(.DIV_W(8)) uut (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .txd(txd), .hs_pin_in(hs_pin_in),
        .hs_pin_out(hs_pin_out), .hs_pin_oe(hs_pin_oe), .irq(irq));
    serial_peer_model peer (.hs_pin_out(hs_pin_out), .hs_pin_oe(hs_pin_oe),
        .cts_n(cts_n), .hs_pin_in(hs_pin_in));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [8:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bus cycles start just after an edge; two cycles keep strobes apart
    task automatic wr(input logic [7:0] a, v);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(posedge clk_sys);
        v = rd_data;
    endtask

    task automatic load(input logic [7:0] ctrl, input logic [1:0] mode);
        wr(`ADDR_BRG, 8'h07);
        wr(`ADDR_MODE, {6'h0, mode});
        wr(`ADDR_CTRL0, ctrl);
        wr(`ADDR_TXDATA, DATA);
    endtask

    // waits for the start bit, then samples each bit near its middle
    task automatic capture(input logic [7:0] ctrl, input logic [1:0] mode,
                           input logic irq_exp);
        int p, n, k;
        logic msb;
        logic [8:0] got, exp;
        p = ctrl[1:0] == `CLK_SRC_F1 ? 8 : (ctrl[1:0] == `CLK_SRC_F8 ? 64 : 256);
        n = mode == `MODE_UART7 ? 7 : (mode == `MODE_UART9 ? 9 : 8);
        msb = ctrl[7] && (mode == `MODE_UART8 || mode == `MODE_SYNC);
        got = 9'h000;
        exp = 9'h000;
        k = 0;
        while (txd !== 1'b0 && k < 4000) begin
            @(posedge clk_sys);
            k++;
        end
        rd(`ADDR_CTRL0, d);
        chk("empty busy", d[3], 1'b0);
        repeat (p / 2 - 2) @(posedge clk_sys);
        chk("start bit", txd, 1'b0);
        for (int i = 0; i < n; i++) begin
            repeat (p) @(posedge clk_sys);
            got[i] = txd;
            exp[i] = msb ? DATA[n-1-i] : (i < 8 ? DATA[i] : 1'b0);
        end
        repeat (p) @(posedge clk_sys);
        chk("stop bit", txd, 1'b1);
        chk("frame bits", got, exp);
        repeat (p) @(posedge clk_sys);
        chk("irq", irq, irq_exp);
        rd(`ADDR_CTRL0, d);
        chk("empty done", d[3], 1'b1);
        rd(`ADDR_IRQ_STATUS, d);
        chk("status", d, 8'h03);
        @(posedge clk_sys);
        chk("irq cleared", irq, 1'b0);
    endtask

    task automatic test_defaults;
        rd(`ADDR_CTRL0, d);
        chk("ctrl0 reset", d, `CTRL0_RESET);
        rd(8'h09, d);
        chk("unmapped", d, 8'h00);
        wr(`ADDR_CTRL0, 8'hf7);
        rd(`ADDR_CTRL0, d);
        chk("ctrl0 fields", d, 8'h9f);
        repeat (6) @(posedge clk_sys);
        wr(`ADDR_CTRL0, 8'h00);
        $display("test defaults done");
    endtask

    task automatic test_pin;
        wr(`ADDR_CTRL0, 8'h04);
        wr(`ADDR_PORT_DIR, 8'h01);
        wr(`ADDR_PORT_DATA, 8'h01);
        repeat (5) @(posedge clk_sys);
        chk("rts oe", hs_pin_oe, 1'b1);
        chk("rts level", hs_pin_out, 1'b0);
        wr(`ADDR_CTRL0, 8'h10);
        repeat (5) @(posedge clk_sys);
        chk("port oe", hs_pin_oe, 1'b1);
        chk("port level", hs_pin_out, 1'b1);
        wr(`ADDR_PORT_DATA, 8'h00);
        wr(`ADDR_PORT_DIR, 8'h00);
        repeat (5) @(posedge clk_sys);
        chk("port released", hs_pin_oe, 1'b0);
        rd(`ADDR_PORT_DATA, d);
        chk("pin high", d[0], 1'b1);
        cts_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(`ADDR_PORT_DATA, d);
        chk("pin low", d[0], 1'b0);
        cts_n <= 1'b1;
        $display("test pin done");
    endtask

    task automatic test_cts;
        int k;
        k = 0;
        wr(`ADDR_IRQ_MASK, 8'h00);
        wr(`ADDR_PORT_DIR, 8'h00);
        load(8'h00, `MODE_UART8);
        repeat (40) begin
            @(posedge clk_sys);
            if (txd !== 1'b1) k++;
        end
        chk("cts hold", k[8:0], 9'h000);
        cts_n <= 1'b0;
        capture(8'h00, `MODE_UART8, 1'b0);
        $display("test cts done");
    endtask

    task automatic test_frames;
        logic [7:0] ctl [4] = '{8'h10, 8'h91, 8'h92, 8'h90};
        logic [1:0] md [4] = '{`MODE_UART8, `MODE_UART8, `MODE_UART7,
                                `MODE_UART9};
        wr(`ADDR_IRQ_MASK, 8'h03);
        for (int i = 0; i < 4; i++) begin
            load(ctl[i], md[i]);
            capture(ctl[i], md[i], 1'b1);
        end
        $display("test frames done");
    endtask

    // sync frames carry no start or stop bit; 8'h5a opens with a zero
    task automatic test_sync;
        logic [7:0] got;
        int k;
        got = 8'h00;
        k = 0;
        wr(`ADDR_MODE, {6'h0, `MODE_SYNC});
        wr(`ADDR_CTRL0, 8'h84);
        wr(`ADDR_TXDATA, 8'h5a);
        @(posedge clk_sys);
        chk("rts full", hs_pin_out, 1'b1);
        while (txd !== 1'b0 && k < 100) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            got = {got[6:0], txd};
            repeat (8) @(posedge clk_sys);
        end
        chk("sync bits", got, 8'h5a);
        chk("sync idle", txd, 1'b1);
        rd(`ADDR_CTRL0, d);
        chk("sync empty", d[3], 1'b1);
        rd(`ADDR_IRQ_STATUS, d);
        chk("sync status", d, 8'h03);
        $display("test sync done");
    endtask

    // hang guard far beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        end_of_test();
    end

    initial begin
        sys_rst = 1'b1;
        {wr_stb, rd_stb} = 2'h0;
        addr = 8'h00;
        wr_data = 8'h00;
        cts_n = 1'b1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        test_defaults();
        test_pin();
        test_cts();
        test_frames();
        test_sync();
        end_of_test();
    end
endmodule
